// ==== bench/bus_partner.sv ====
`timescale 1ns/1ns
`default_nettype none
// Remote party on the two-wire bus: pulls the lines and raises link events.
module bus_partner (
    // Link clock.
    input wire logic link_clk_in,
    // Line pull-downs and event pulses.
    output logic scl_low_out,
    output logic sda_low_out,
    output logic gen_call_ack_out,
    output logic slave_tx_nack_out
);
    // Released lines float to the pull-up level, so idle is high.
    initial begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
        gen_call_ack_out = 1'b0;
        slave_tx_nack_out = 1'b0;
    end
    // Start then stop; each level holds several link cycles so the pin filter sees it settled.
    task automatic frame();
        @(posedge link_clk_in) sda_low_out <= 1'b1;
        repeat (4) @(posedge link_clk_in);
        scl_low_out <= 1'b1;
        repeat (4) @(posedge link_clk_in);
        scl_low_out <= 1'b0;
        repeat (4) @(posedge link_clk_in);
        sda_low_out <= 1'b0;
    endtask
    // One-link-cycle pulse; events stay at least one link cycle apart.
    task automatic pulse(input logic gc);
        @(posedge link_clk_in) gen_call_ack_out <= gc;
        slave_tx_nack_out <= ~gc;
        @(posedge link_clk_in) gen_call_ack_out <= 1'b0;
        slave_tx_nack_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== bench/i2c_scl_timing_and_status_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
// Register-level bench for the clock period counts and upper raw status.
module i2c_scl_timing_and_status_bench;
    logic core_clk_in = 1'b0, rst_in = 1'b1, lclk = 1'b0, en = 1'b0, ce = 1'b1, act = 1'b0, run = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, idle, scl_oe, p_scl, p_sda, gc, nack, rdy, serr, serr_s;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdata;
    int error_cnt = 0, check_count = 0, n = 0;
    wire logic scl_w = ~(scl_oe | p_scl);
    wire logic sda_w = ~p_sda;
    // Core and link clocks, unrelated in phase.
    always #10 core_clk_in = ~core_clk_in;
    always begin
        #62 lclk = 1'b1;
        #63 lclk = 1'b0;
    end
    scl_timing_status i_scl_timing_status (.core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(ce),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(rdy), .pslverr_out(serr), .ctrl_enable_in(en), .ctrl_activity_in(act),
        .low_status_in(7'h55), .speed_mode_in(scl_timing_pkg::SPEED_STD), .hs_preamble_in(1'b0),
        .scl_run_in(run), .bus_idle_out(idle), .link_clk_in(lclk), .gen_call_ack_in(gc),
        .slave_tx_nack_in(nack), .scl_pin_in(scl_w), .sda_pin_in(sda_w), .scl_out(), .scl_oe_out(scl_oe));
    bus_partner i_bus_partner (.link_clk_in(lclk), .scl_low_out(p_scl), .sda_low_out(p_sda),
        .gen_call_ack_out(gc), .slave_tx_nack_out(nack));
    // Setup then access phase; read data is taken at the access edge.
    task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk_in) #1 psel = 1'b1;
        pwrite = wr;
        paddr = a;
        pwdata = d;
        @(posedge core_clk_in) #1 penable = 1'b1;
        @(posedge core_clk_in);
        while (rdy !== 1'b1) @(posedge core_clk_in);
        rdata = prdata;
        serr_s = serr;
        #1 psel = 1'b0;
        penable = 1'b0;
    endtask
    task automatic check(input string what, input logic [31:0] exp);
        check_count++;
        if (rdata !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, rdata);
        end
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
        acc(1'b0, a, 32'h0);
        check(what, exp);
    endtask
    task automatic end_sim();
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run length.
    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end
    // Main sequence; counts are programmed before any bus traffic.
    initial begin
        repeat (4) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        rd(scl_timing_pkg::ADDR_STD_HIGH, 32'h48, "std high");
        rd(scl_timing_pkg::ADDR_STD_LOW, 32'h4F, "std low");
        rd(scl_timing_pkg::ADDR_FAST_HIGH, 32'h8, "fast high");
        rd(scl_timing_pkg::ADDR_FAST_LOW, 32'h17, "fast low");
        rd(scl_timing_pkg::ADDR_RAW_STATUS, 32'h55, "status");
        acc(1'b1, scl_timing_pkg::ADDR_STD_LOW, 32'h3);
        rd(scl_timing_pkg::ADDR_STD_LOW, 32'h8, "std low min");
        acc(1'b1, scl_timing_pkg::ADDR_FAST_HIGH, 32'h5);
        rd(scl_timing_pkg::ADDR_FAST_HIGH, 32'h6, "fast high min");
        acc(1'b1, scl_timing_pkg::ADDR_FAST_LOW, 32'h7);
        rd(scl_timing_pkg::ADDR_FAST_LOW, 32'h8, "fast low min");
        acc(1'b1, scl_timing_pkg::ADDR_STD_HIGH, 32'h0);
        rd(scl_timing_pkg::ADDR_STD_HIGH, 32'h6, "std high min");
        acc(1'b1, scl_timing_pkg::ADDR_FAST_LOW, 32'hABCD);
        rd(scl_timing_pkg::ADDR_FAST_LOW, 32'hABCD, "fast low");
        acc(1'b1, scl_timing_pkg::ADDR_RAW_STATUS, 32'hFFFF);
        rd(scl_timing_pkg::ADDR_RAW_STATUS, 32'h55, "status write");
        ce = 1'b0;
        acc(1'b1, scl_timing_pkg::ADDR_STD_LOW, 32'h20);
        ce = 1'b1;
        rd(scl_timing_pkg::ADDR_STD_LOW, 32'h8, "frozen std low");
        en = 1'b1;
        acc(1'b1, scl_timing_pkg::ADDR_STD_LOW, 32'h100);
        rd(scl_timing_pkg::ADDR_STD_LOW, 32'h8, "locked std low");
        // Events land while enabled, because disable would clear the general call and activity flags.
        i_bus_partner.frame();
        repeat (40) @(posedge core_clk_in);
        rd(scl_timing_pkg::ADDR_RAW_STATUS, 32'h755, "start stop");
        acc(1'b0, scl_timing_pkg::ADDR_ACTIVITY_CLEAR, 32'h0);
        rd(scl_timing_pkg::ADDR_RAW_STATUS, 32'h655, "activity clear");
        i_bus_partner.pulse(1'b1);
        repeat (8) @(posedge core_clk_in);
        rd(scl_timing_pkg::ADDR_RAW_STATUS, 32'hE55, "gen call");
        acc(1'b0, scl_timing_pkg::ADDR_GEN_CALL_CLEAR, 32'h0);
        rd(scl_timing_pkg::ADDR_RAW_STATUS, 32'h655, "gen call clear");
        i_bus_partner.pulse(1'b0);
        repeat (8) @(posedge core_clk_in);
        rd(scl_timing_pkg::ADDR_RAW_STATUS, 32'h6D5, "tx done");
        acc(1'b0, scl_timing_pkg::ADDR_ALL_CLEAR, 32'h0);
        rd(scl_timing_pkg::ADDR_RAW_STATUS, 32'h55, "all clear");
        rdata = {31'h0, idle};
        check("bus idle", 32'h1);
        rd(32'h5000_1524, 32'h0, "unmapped");
        rdata = {31'h0, serr_s};
        check("slave error", 32'h1);
        // Disable is the remaining clear path of the general call and activity flags.
        act = 1'b1;
        @(posedge core_clk_in) #1 act = 1'b0;
        i_bus_partner.pulse(1'b1);
        repeat (8) @(posedge core_clk_in);
        rd(scl_timing_pkg::ADDR_RAW_STATUS, 32'h955, "gen call activity");
        en = 1'b0;
        rd(scl_timing_pkg::ADDR_RAW_STATUS, 32'h55, "disable clear");
        // Standard timing now holds low 8 and high 6, so 28 samples span two whole periods.
        en = 1'b1;
        run = 1'b1;
        repeat (28) begin
            @(posedge core_clk_in);
            #1 n = n + scl_oe;
        end
        run = 1'b0;
        rdata = n;
        check("clock low cycles", 32'h10);
        end_sim();
    end
endmodule
`default_nettype wire

// ==== design/bit_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; stage one feeds only stage two.
module bit_sync #(
    parameter int WIDTH = 1
) (
    // Clock, reset and enable.
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Data.
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] s2_out,
    output logic [WIDTH-1:0] s3_out
);
    logic [WIDTH-1:0] s1;

    // Shift the input through three flops.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s1 <= '0;
            s2_out <= '0;
            s3_out <= '0;
        end else if (ce_in) begin
            s1 <= d_in;
            s2_out <= s1;
            s3_out <= s2_out;
        end
    end
endmodule
`default_nettype wire

// ==== design/scl_period_gen.sv ====
`timescale 1ns/1ns
`default_nettype none
// Serial clock generator: low then high phase, each a programmed count.
module scl_period_gen (
    // Clock, reset and enable.
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Control.
    input wire logic run_in,
    input wire logic [15:0] high_count_in,
    input wire logic [15:0] low_count_in,
    // Serial clock drive.
    output logic scl_low_out
);
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_LOW = 2'b01,
        PH_HIGH = 2'b10
    } phase_t;

    phase_t phase;
    logic [15:0] cnt;

    // Each phase lasts exactly its count in controller cycles.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            phase <= PH_IDLE;
            cnt <= 16'h0000;
        end else if (ce_in) begin
            case (phase)
                PH_IDLE: begin
                    cnt <= 16'h0000;
                    if (run_in) begin
                        phase <= PH_LOW;
                    end
                end
                PH_LOW: begin
                    if (cnt >= low_count_in - 16'h0001) begin
                        cnt <= 16'h0000;
                        phase <= PH_HIGH;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                PH_HIGH: begin
                    if (cnt >= high_count_in - 16'h0001) begin
                        cnt <= 16'h0000;
                        phase <= run_in ? PH_LOW : PH_IDLE;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                default: begin
                    phase <= PH_IDLE;
                    cnt <= 16'h0000;
                end
            endcase
        end
    end

    assign scl_low_out = (phase == PH_LOW);

    a_low_bound: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (phase == PH_LOW && low_count_in != 16'h0000) |-> cnt < low_count_in)
        else $error("low phase count ran past its programmed length");
endmodule
`default_nettype wire

// ==== design/scl_timing_pkg.sv ====
package scl_timing_pkg;

    // Register byte addresses on the peripheral bus.
    localparam logic [31:0] ADDR_STD_HIGH = 32'h5000_1514;
    localparam logic [31:0] ADDR_STD_LOW = 32'h5000_1518;
    localparam logic [31:0] ADDR_FAST_HIGH = 32'h5000_151C;
    localparam logic [31:0] ADDR_FAST_LOW = 32'h5000_1520;
    localparam logic [31:0] ADDR_RAW_STATUS = 32'h5000_152C;
    localparam logic [31:0] ADDR_ALL_CLEAR = 32'h5000_1540;
    localparam logic [31:0] ADDR_ACTIVITY_CLEAR = 32'h5000_155C;
    localparam logic [31:0] ADDR_GEN_CALL_CLEAR = 32'h5000_1568;

    // Reset values and stored minimums of the period counts.
    localparam logic [15:0] RESET_STD_HIGH = 16'h0048;
    localparam logic [15:0] RESET_STD_LOW = 16'h004F;
    localparam logic [15:0] RESET_FAST_HIGH = 16'h0008;
    localparam logic [15:0] RESET_FAST_LOW = 16'h0017;
    localparam logic [15:0] MIN_HIGH_COUNT = 16'h0006;
    localparam logic [15:0] MIN_LOW_COUNT = 16'h0008;

    // Idle detection margin above the standard high count.
    localparam logic [16:0] IDLE_MARGIN = 17'h0000A;

    // Raw status field positions.
    localparam int BIT_GEN_CALL = 11;
    localparam int BIT_START = 10;
    localparam int BIT_STOP = 9;
    localparam int BIT_ACTIVITY = 8;
    localparam int BIT_RX_DONE = 7;

    // Link event bit positions in the crossing vector.
    localparam int EV_START = 0;
    localparam int EV_STOP = 1;
    localparam int EV_GEN_CALL = 2;
    localparam int EV_RX_DONE = 3;
    localparam int EV_COUNT = 4;

    // Bus speed selections.
    localparam logic [1:0] SPEED_STD = 2'h1;
    localparam logic [1:0] SPEED_FAST = 2'h2;
    localparam logic [1:0] SPEED_HIGH = 2'h3;

endpackage

// ==== design/scl_timing_status.sv ====
`timescale 1ns/1ns
`default_nettype none
// Serial clock period counts and upper raw status for the two-wire controller.
module scl_timing_status (
    // Core clock, reset and freeze.
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // Peripheral register port.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Controller side signals.
    input wire logic ctrl_enable_in,
    input wire logic ctrl_activity_in,
    input wire logic [6:0] low_status_in,
    input wire logic [1:0] speed_mode_in,
    input wire logic hs_preamble_in,
    input wire logic scl_run_in,
    output logic bus_idle_out,
    // Link clock and link side events.
    input wire logic link_clk_in,
    input wire logic gen_call_ack_in,
    input wire logic slave_tx_nack_in,
    // Bus pins.
    input wire logic scl_pin_in,
    input wire logic sda_pin_in,
    output logic scl_out,
    output logic scl_oe_out
);
    localparam int EV_COUNT_W = scl_timing_pkg::EV_COUNT;

    logic [15:0] std_high_period_count;
    logic [15:0] std_low_period_count;
    logic [15:0] fast_high_period_count;
    logic [15:0] fast_low_period_count;
    logic general_call_seen_flag;
    logic start_condition_flag;
    logic stop_condition_flag;
    logic activity_flag;
    logic rx_done_flag;
    logic wr_access;
    logic rd_access;
    logic addr_hit;
    logic cfg_write_ok;
    logic general_call_flag_clear;
    logic activity_flag_clear;
    logic all_flags_clear;
    logic [15:0] raw_status;
    logic use_fast;
    logic [15:0] active_high;
    logic [15:0] active_low;
    logic [15:0] idle_cnt;
    logic [16:0] idle_limit;
    logic link_rst;
    logic link_rst_s2;
    logic link_rst_s3;
    logic scl_s2;
    logic scl_s3;
    logic sda_s2;
    logic sda_s3;
    logic scl_f;
    logic sda_f;
    logic [EV_COUNT_W-1:0] ev_tog;
    logic [EV_COUNT_W-1:0] ev_s2;
    logic [EV_COUNT_W-1:0] ev_s3;
    logic [EV_COUNT_W-1:0] ev_core;
    logic start_det;
    logic stop_det;
    logic bus_free_link;
    logic bus_free_s2;
    logic bus_free_s3;

    // Holds a written low or high count at its stored minimum.
    function automatic logic [15:0] clamp_min(input logic [15:0] v, input logic [15:0] m);
        clamp_min = (v < m) ? m : v;
    endfunction

    // Bus decode: address in setup phase, action in access phase.
    assign wr_access = psel_in && penable_in && pwrite_in;
    assign rd_access = psel_in && penable_in && !pwrite_in;
    assign addr_hit = (paddr_in == scl_timing_pkg::ADDR_STD_HIGH) ||
                      (paddr_in == scl_timing_pkg::ADDR_STD_LOW) ||
                      (paddr_in == scl_timing_pkg::ADDR_FAST_HIGH) ||
                      (paddr_in == scl_timing_pkg::ADDR_FAST_LOW) ||
                      (paddr_in == scl_timing_pkg::ADDR_RAW_STATUS) ||
                      (paddr_in == scl_timing_pkg::ADDR_ALL_CLEAR) ||
                      (paddr_in == scl_timing_pkg::ADDR_ACTIVITY_CLEAR) ||
                      (paddr_in == scl_timing_pkg::ADDR_GEN_CALL_CLEAR);
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !addr_hit;
    // Period counts only move while the controller is off; a live change would tear a bit time.
    assign cfg_write_ok = wr_access && !ctrl_enable_in && clk_en_in;

    // Reads of the clear registers have a side effect on the flags.
    assign general_call_flag_clear = rd_access && (paddr_in == scl_timing_pkg::ADDR_GEN_CALL_CLEAR);
    assign activity_flag_clear = rd_access && (paddr_in == scl_timing_pkg::ADDR_ACTIVITY_CLEAR);
    assign all_flags_clear = rd_access && (paddr_in == scl_timing_pkg::ADDR_ALL_CLEAR);

    // Standard and fast period counts with write clamping.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            std_high_period_count <= scl_timing_pkg::RESET_STD_HIGH;
            std_low_period_count <= scl_timing_pkg::RESET_STD_LOW;
            fast_high_period_count <= scl_timing_pkg::RESET_FAST_HIGH;
            fast_low_period_count <= scl_timing_pkg::RESET_FAST_LOW;
        end else if (cfg_write_ok) begin
            if (paddr_in == scl_timing_pkg::ADDR_STD_HIGH) begin
                std_high_period_count <= clamp_min(pwdata_in[15:0], scl_timing_pkg::MIN_HIGH_COUNT);
            end
            if (paddr_in == scl_timing_pkg::ADDR_STD_LOW) begin
                std_low_period_count <= clamp_min(pwdata_in[15:0], scl_timing_pkg::MIN_LOW_COUNT);
            end
            if (paddr_in == scl_timing_pkg::ADDR_FAST_HIGH) begin
                fast_high_period_count <= clamp_min(pwdata_in[15:0], scl_timing_pkg::MIN_HIGH_COUNT);
            end
            if (paddr_in == scl_timing_pkg::ADDR_FAST_LOW) begin
                fast_low_period_count <= clamp_min(pwdata_in[15:0], scl_timing_pkg::MIN_LOW_COUNT);
            end
        end
    end

    // Raw status: reserved nibble is zero, lower bits come from the controller.
    assign raw_status = {4'h0, general_call_seen_flag, start_condition_flag,
                         stop_condition_flag, activity_flag, rx_done_flag, low_status_in};

    // Read data is registered in the setup phase; writes to status fall through decode.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (clk_en_in && psel_in && !penable_in && !pwrite_in) begin
            case (paddr_in)
                scl_timing_pkg::ADDR_STD_HIGH: prdata_out <= {16'h0000, std_high_period_count};
                scl_timing_pkg::ADDR_STD_LOW: prdata_out <= {16'h0000, std_low_period_count};
                scl_timing_pkg::ADDR_FAST_HIGH: prdata_out <= {16'h0000, fast_high_period_count};
                scl_timing_pkg::ADDR_FAST_LOW: prdata_out <= {16'h0000, fast_low_period_count};
                scl_timing_pkg::ADDR_RAW_STATUS: prdata_out <= {16'h0000, raw_status};
                default: prdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // Link domain reset follows the core reset through a level crossing.
    bit_sync #(.WIDTH(1)) u_link_rst (
        .clk_in(link_clk_in),
        .rst_in(1'b0),
        .ce_in(1'b1),
        .d_in(rst_in),
        .s2_out(link_rst_s2),
        .s3_out(link_rst_s3)
    );
    // Both reset stages reach the link flops, so a short core reset still covers two link edges.
    assign link_rst = link_rst_s2 || link_rst_s3;

    // Pin sampling: a change is accepted once stages two and three agree.
    bit_sync #(.WIDTH(2)) u_pin_sync (
        .clk_in(link_clk_in),
        .rst_in(link_rst),
        .ce_in(1'b1),
        .d_in({scl_pin_in, sda_pin_in}),
        .s2_out({scl_s2, sda_s2}),
        .s3_out({scl_s3, sda_s3})
    );

    // Filtered line levels; idle bus reads high on both lines.
    always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
            scl_f <= 1'b1;
            sda_f <= 1'b1;
        end else begin
            if (scl_s2 == scl_s3) begin
                scl_f <= scl_s3;
            end
            if (sda_s2 == sda_s3) begin
                sda_f <= sda_s3;
            end
        end
    end

    // Start and stop: data line moves while the clock line stays high.
    assign start_det = scl_f && scl_s3 && (scl_s2 == scl_s3) && sda_f && !sda_s3 && (sda_s2 == sda_s3);
    assign stop_det = scl_f && scl_s3 && (scl_s2 == scl_s3) && !sda_f && sda_s3 && (sda_s2 == sda_s3);
    assign bus_free_link = scl_f && sda_f;

    // Each link event flips a toggle so that no pulse is lost in the crossing.
    always_ff @(posedge link_clk_in) begin
        if (link_rst) begin
            ev_tog <= '0;
        end else begin
            ev_tog[scl_timing_pkg::EV_START] <= ev_tog[scl_timing_pkg::EV_START] ^ start_det;
            ev_tog[scl_timing_pkg::EV_STOP] <= ev_tog[scl_timing_pkg::EV_STOP] ^ stop_det;
            ev_tog[scl_timing_pkg::EV_GEN_CALL] <= ev_tog[scl_timing_pkg::EV_GEN_CALL] ^ gen_call_ack_in;
            ev_tog[scl_timing_pkg::EV_RX_DONE] <= ev_tog[scl_timing_pkg::EV_RX_DONE] ^ slave_tx_nack_in;
        end
    end

    // Toggles and the free-bus level enter the core domain.
    bit_sync #(.WIDTH(EV_COUNT_W + 1)) u_core_sync (
        .clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(clk_en_in),
        .d_in({bus_free_link, ev_tog}),
        .s2_out({bus_free_s2, ev_s2}),
        .s3_out({bus_free_s3, ev_s3})
    );
    assign ev_core = (ev_s2 ^ ev_s3) & {EV_COUNT_W{clk_en_in}};

    // General call: set wins over the clear read and over disable.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            general_call_seen_flag <= 1'b0;
        end else if (ev_core[scl_timing_pkg::EV_GEN_CALL]) begin
            general_call_seen_flag <= 1'b1;
        end else if (clk_en_in && (!ctrl_enable_in || general_call_flag_clear)) begin
            general_call_seen_flag <= 1'b0;
        end
    end

    // Start and stop flags clear only through the combined clear read.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            start_condition_flag <= 1'b0;
            stop_condition_flag <= 1'b0;
        end else begin
            if (ev_core[scl_timing_pkg::EV_START]) begin
                start_condition_flag <= 1'b1;
            end else if (clk_en_in && all_flags_clear) begin
                start_condition_flag <= 1'b0;
            end
            if (ev_core[scl_timing_pkg::EV_STOP]) begin
                stop_condition_flag <= 1'b1;
            end else if (clk_en_in && all_flags_clear) begin
                stop_condition_flag <= 1'b0;
            end
        end
    end

    // Activity is sticky; it survives the controller going idle.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            activity_flag <= 1'b0;
        end else if (clk_en_in && (ctrl_activity_in || ev_core[scl_timing_pkg::EV_START])) begin
            activity_flag <= 1'b1;
        end else if (clk_en_in && (!ctrl_enable_in || activity_flag_clear || all_flags_clear)) begin
            activity_flag <= 1'b0;
        end
    end

    // Slave transmit finished: the master left the last byte unacknowledged.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rx_done_flag <= 1'b0;
        end else if (ev_core[scl_timing_pkg::EV_RX_DONE]) begin
            rx_done_flag <= 1'b1;
        end else if (clk_en_in && all_flags_clear) begin
            rx_done_flag <= 1'b0;
        end
    end

    // Speed selection; the high-speed preamble runs at fast timing.
    assign use_fast = (speed_mode_in == scl_timing_pkg::SPEED_FAST) ||
                      ((speed_mode_in == scl_timing_pkg::SPEED_HIGH) && hs_preamble_in);
    assign active_high = use_fast ? fast_high_period_count : std_high_period_count;
    assign active_low = use_fast ? fast_low_period_count : std_low_period_count;

    // High-speed data phase timing lives elsewhere, so the generator rests then.
    scl_period_gen u_scl_gen (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .ce_in(clk_en_in),
        .run_in(scl_run_in && ctrl_enable_in && (use_fast || speed_mode_in == scl_timing_pkg::SPEED_STD)),
        .high_count_in(active_high),
        .low_count_in(active_low),
        .scl_low_out(scl_oe_out)
    );
    assign scl_out = 1'b0;

    // Idle counter is 16 bits; a high count above 65525 would never reach the limit.
    assign idle_limit = {1'b0, std_high_period_count} + scl_timing_pkg::IDLE_MARGIN;
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            idle_cnt <= 16'h0000;
        end else if (clk_en_in) begin
            if (!bus_free_s3) begin
                idle_cnt <= 16'h0000;
            end else if ({1'b0, idle_cnt} < idle_limit) begin
                idle_cnt <= idle_cnt + 16'h0001;
            end
        end
    end
    assign bus_idle_out = ({1'b0, idle_cnt} >= idle_limit);

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    a_reset_values: assert property ($past(rst_in) |->
        std_low_period_count == scl_timing_pkg::RESET_STD_LOW &&
        fast_high_period_count == scl_timing_pkg::RESET_FAST_HIGH &&
        fast_low_period_count == scl_timing_pkg::RESET_FAST_LOW &&
        std_high_period_count == scl_timing_pkg::RESET_STD_HIGH)
        else $error("period counts lost their reset values");
    a_low_clamp: assert property (cfg_write_ok && paddr_in == scl_timing_pkg::ADDR_STD_LOW
        |=> std_low_period_count == clamp_min($past(pwdata_in[15:0]), scl_timing_pkg::MIN_LOW_COUNT))
        else $error("standard low count not stored with its minimum");
    a_fast_high_clamp: assert property (cfg_write_ok && paddr_in == scl_timing_pkg::ADDR_FAST_HIGH
        |=> fast_high_period_count == clamp_min($past(pwdata_in[15:0]), scl_timing_pkg::MIN_HIGH_COUNT))
        else $error("fast high count not stored with its minimum");
    a_std_high_clamp: assert property (cfg_write_ok && paddr_in == scl_timing_pkg::ADDR_STD_HIGH
        |=> std_high_period_count >= scl_timing_pkg::MIN_HIGH_COUNT)
        else $error("standard high count below its minimum");
    a_write_locked: assert property (ctrl_enable_in |=> $stable(fast_low_period_count) &&
        $stable(std_low_period_count) && $stable(fast_high_period_count))
        else $error("period count changed while the controller was enabled");
    a_preamble_fast: assert property (speed_mode_in == scl_timing_pkg::SPEED_HIGH && hs_preamble_in
        |-> active_high == fast_high_period_count && active_low == fast_low_period_count)
        else $error("high-speed preamble not using fast timing");
    a_gencall_clear: assert property (clk_en_in && general_call_flag_clear &&
        !ev_core[scl_timing_pkg::EV_GEN_CALL] |=> !general_call_seen_flag)
        else $error("general call flag survived its clear read");
    a_activity_sticky: assert property (activity_flag && clk_en_in && ctrl_enable_in &&
        !activity_flag_clear && !all_flags_clear |=> activity_flag)
        else $error("activity flag dropped without a clear");
    a_stop_sets: assert property (ev_core[scl_timing_pkg::EV_STOP] |=> stop_condition_flag)
        else $error("stop event did not set its flag");
    a_rx_done_sets: assert property (ev_core[scl_timing_pkg::EV_RX_DONE] |=> rx_done_flag)
        else $error("slave transmit done event did not set its flag");
    a_reserved_zero: assert property (psel_in && !penable_in && !pwrite_in && clk_en_in &&
        paddr_in == scl_timing_pkg::ADDR_RAW_STATUS |=> prdata_out[31:12] == 20'h00000)
        else $error("reserved status bits read nonzero");
    a_idle_reach: assert property (bus_free_s3 && clk_en_in && !bus_idle_out |=>
        idle_cnt == $past(idle_cnt) + 16'h0001)
        else $error("idle counter did not advance on a free bus");
    a_start_toggle: assert property (@(posedge link_clk_in) disable iff (link_rst)
        start_det |=> ev_tog[scl_timing_pkg::EV_START] != $past(ev_tog[scl_timing_pkg::EV_START]))
        else $error("start condition did not flip its toggle");

    c_start_seen: cover property (ev_core[scl_timing_pkg::EV_START]);
    c_gen_call_cleared: cover property (general_call_seen_flag ##1 !general_call_seen_flag);
    c_clamped_write: cover property (cfg_write_ok && pwdata_in[15:0] < scl_timing_pkg::MIN_HIGH_COUNT);
    c_bus_idle: cover property (!bus_idle_out ##1 bus_idle_out);
endmodule
`default_nettype wire
